// ### ascc_pkg.sv
// Package of register offsets, field positions and reset values for the serial control block.
package ascc_pkg;
  // Word byte addresses of the registers on the bus.
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h4;
  localparam logic [3:0] ADDR_CTRL_THREE = 4'h8;
  localparam logic [3:0] ADDR_STATUS_ONE = 4'hC;
  localparam int ADDR_W = 4;
  // Control one field positions.
  localparam int C1_PTY = 0;
  localparam int C1_PEN = 1;
  localparam int C1_WAKE = 3;
  localparam int C1_M = 4;
  localparam int C1_ENA = 6;
  // Control two field positions.
  localparam int C2_SBK = 0;
  localparam int C2_RWU = 1;
  localparam int C2_RE = 2;
  localparam int C2_TE = 3;
  localparam int C2_IDLE_LINE_IRQ_EN = 4;
  localparam int C2_RIE = 5;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_TIE = 7;
  // Control three field positions.
  localparam int C3_PARITY_ERR_IRQ_EN = 0;
  localparam int C3_FRAMING_IRQ_EN = 1;
  localparam int C3_NOISE_IRQ_EN = 2;
  localparam int C3_OVERRUN_IRQ_EN = 3;
  localparam int C3_DTE = 4;
  localparam int C3_DRE = 5;
  localparam int C3_T8 = 6;
  localparam int C3_R8 = 7;
  // Status one field positions.
  localparam int S1_PE = 0;
  localparam int S1_FE = 1;
  localparam int S1_NF = 2;
  localparam int S1_OR = 3;
  localparam int S1_IDLE = 4;
  localparam int S1_RF = 5;
  localparam int S1_TC = 6;
  localparam int S1_TE = 7;
  // Reset values of the writable registers.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Frame lengths in bit times.
  localparam logic [3:0] FRAME_SHORT = 4'hA;
  localparam logic [3:0] FRAME_LONG = 4'hB;
  // Bit period in clock cycles.
  localparam int BIT_CYCLES = 16;
  // Transmit line states.
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BREAK} ascc_tx_e;
endpackage

// ### ascc_shifter.sv
// Transmit shift register with bit timing for the serial control block.
`timescale 1ns/10ps
`default_nettype none
module ascc_shifter #(
  parameter int BITS = 16 // Clock cycles per bit.
) (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic load_i, // Load a frame pulse.
  input wire logic [10:0] frame_i, // Frame, LSB first.
  input wire logic [3:0] len_i, // Frame length in bits.
  output logic busy_o, // Frame in progress.
  output logic line_o // Serial line level.
);
  logic [10:0] sh_reg; // Remaining bits.
  logic [3:0] cnt_reg; // Bits left.
  logic [15:0] tick_reg; // Bit timer.

  // Shifts one bit per bit period; the line idles high.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sh_reg <= 11'h7FF;
      cnt_reg <= 4'h0;
      tick_reg <= 16'h0000;
      busy_o <= 1'b0;
      line_o <= 1'b1;
    end else if (load_i && !busy_o) begin
      sh_reg <= {1'b1, frame_i[10:1]};
      line_o <= frame_i[0];
      cnt_reg <= len_i;
      tick_reg <= 16'(BITS - 1);
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (tick_reg != 16'h0000) begin
        tick_reg <= tick_reg - 16'h0001;
      end else if (cnt_reg == 4'h1) begin
        busy_o <= 1'b0;
        line_o <= 1'b1;
      end else begin
        line_o <= sh_reg[0];
        sh_reg <= {1'b1, sh_reg[10:1]};
        cnt_reg <= cnt_reg - 4'h1;
        tick_reg <= 16'(BITS - 1);
      end
    end
  end
endmodule
`default_nettype wire

// ### ascc_top.sv
// Control and configuration logic of an asynchronous serial interface.
`timescale 1ns/10ps
`default_nettype none
module ascc_top
  import ascc_pkg::*;
#(
  parameter int BIT_CYC = ascc_pkg::BIT_CYCLES // Clock cycles per bit.
) (
  input wire logic ref_clk_i, // Clock, 200 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [ascc_pkg::ADDR_W-1:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Acknowledge.
  input wire logic [7:0] tx_data_i, // Data register contents to send.
  input wire logic tx_data_valid_i, // Data register holds a character.
  output logic tx_data_taken_o, // Pulse: data moved to shifter.
  input wire logic rx_load_i, // Pulse: received character moved to data.
  input wire logic [8:0] rx_char_i, // Received character bits.
  input wire logic rx_full_flag_i, // Receiver full flag.
  input wire logic rx_idle_flag_i, // Receiver idle flag.
  input wire logic rx_idle_wake_i, // Pulse: idle character seen.
  input wire logic overrun_flag_i, // Receiver overrun flag.
  input wire logic noise_flag_i, // Noise flag.
  input wire logic framing_flag_i, // Framing flag.
  input wire logic parity_err_flag_i, // Parity error flag.
  output logic tx_line_o, // Transmit line.
  output logic rx_on_o, // Receiver enabled and module on.
  output logic parity_odd_o, // Parity type for the receiver checker.
  output logic tx_irq_o, // Transmitter request.
  output logic rx_irq_o, // Receiver request.
  output logic err_irq_o // Error request.
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [7:0] ctrl1_reg; // Control one.
  logic [7:0] ctrl2_reg; // Control two.
  logic [5:0] ctrl3_reg; // Control three writable low bits.
  logic tx_ninth_bit_reg; // Ninth transmit bit, not reset.
  logic rx_ninth_bit_reg; // Ninth received bit, not reset.
  logic tx_empty_flag_reg; // Transmit empty flag.
  logic tx_done_flag_reg; // Transmission complete flag.
  logic idle_pending_reg; // Idle character queued.
  logic break_pending_reg; // One break owed after a toggle.
  logic te_prev_reg; // Last transmitter enable.
  ascc_tx_e tx_state_reg; // Transmit sequencer.
  logic load_reg; // Shifter load strobe.
  logic [10:0] frame_reg; // Frame for the shifter.
  logic shifter_busy; // Shifter active.
  logic shifter_line; // Shifter line.
  logic hit; // Bus request.
  logic [7:0] rd_byte; // Read mux.
  logic wr; // Write taken.
  logic long_fmt; // Eleven bit frame.
  logic module_enable;
  logic tx_enable;
  logic send_break;
  logic rx_standby;
  logic [8:0] payload; // Nine character bits.
  logic parity_bit;

  assign module_enable = ctrl1_reg[C1_ENA];
  assign tx_enable = ctrl2_reg[C2_TE];
  assign send_break = ctrl2_reg[C2_SBK];
  assign rx_standby = ctrl2_reg[C2_RWU];
  assign long_fmt = ctrl1_reg[C1_M];
  assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = hit && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, low for one cycle after.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= hit;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      ADDR_CTRL_ONE: rd_byte = ctrl1_reg;
      ADDR_CTRL_TWO: rd_byte = ctrl2_reg;
      ADDR_CTRL_THREE: rd_byte = {rx_ninth_bit_reg, tx_ninth_bit_reg, ctrl3_reg};
      ADDR_STATUS_ONE: begin
        rd_byte[S1_TE] = tx_empty_flag_reg;
        rd_byte[S1_TC] = tx_done_flag_reg;
        rd_byte[S1_RF] = rx_full_flag_i;
        rd_byte[S1_IDLE] = rx_idle_flag_i;
        rd_byte[S1_OR] = overrun_flag_i;
        rd_byte[S1_NF] = noise_flag_i;
        rd_byte[S1_FE] = framing_flag_i;
        rd_byte[S1_PE] = parity_err_flag_i;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control one: format, parity, wake select, module enable.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl1_reg <= CTRL_RESET;
    end else if (wr && wb_adr_i == ADDR_CTRL_ONE) begin
      ctrl1_reg <= wb_dat_i[7:0];
    end
  end

  // Control two; hardware clears standby on the selected wake condition.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl2_reg <= CTRL_RESET;
    end else if (wr && wb_adr_i == ADDR_CTRL_TWO) begin
      ctrl2_reg <= wb_dat_i[7:0];
    end else if (rx_standby && ctrl1_reg[C1_WAKE] && rx_load_i
                 && (long_fmt ? rx_char_i[8] : rx_char_i[7])) begin
      ctrl2_reg[C2_RWU] <= 1'b0;
    end else if (rx_standby && !ctrl1_reg[C1_WAKE] && rx_idle_wake_i) begin
      ctrl2_reg[C2_RWU] <= 1'b0;
    end
  end

  // Control three: enables reset, ninth transmit bit unaffected by reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl3_reg <= 6'h00;
    end else if (wr && wb_adr_i == ADDR_CTRL_THREE) begin
      ctrl3_reg <= wb_dat_i[5:0];
    end
  end

  // Ninth transmit bit holds through reset.
  always_ff @(posedge ref_clk_i) begin
    if (wr && wb_adr_i == ADDR_CTRL_THREE) begin
      tx_ninth_bit_reg <= wb_dat_i[C3_T8];
    end
  end

  // Ninth received bit is bit 8 or a copy of bit 7, with the data load.
  always_ff @(posedge ref_clk_i) begin
    if (rx_load_i) begin
      rx_ninth_bit_reg <= long_fmt ? rx_char_i[8] : rx_char_i[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character assembly: parity replaces the most significant bit.
  always_comb begin
    payload = {tx_ninth_bit_reg, tx_data_i};
    parity_bit = 1'b0;
    if (ctrl1_reg[C1_PEN]) begin
      if (long_fmt) begin
        parity_bit = ^tx_data_i ^ ctrl1_reg[C1_PTY];
        payload[8] = parity_bit;
      end else begin
        parity_bit = ^tx_data_i[6:0] ^ ctrl1_reg[C1_PTY];
        payload[7] = parity_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer: preamble, data, break and idle characters.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      load_reg <= 1'b0;
      frame_reg <= 11'h7FF;
      tx_data_taken_o <= 1'b0;
      te_prev_reg <= 1'b0;
      idle_pending_reg <= 1'b0;
      break_pending_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      tx_data_taken_o <= 1'b0;
      te_prev_reg <= tx_enable;
      if (tx_enable && !te_prev_reg && shifter_busy) begin
        idle_pending_reg <= 1'b1;
      end
      if (wr && wb_adr_i == ADDR_CTRL_TWO && !send_break && wb_dat_i[C2_SBK]) begin
        break_pending_reg <= 1'b1;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          if (module_enable && tx_enable && !te_prev_reg) begin
            tx_state_reg <= TX_PRE;
          end else if (module_enable && tx_enable) begin
            tx_state_reg <= TX_DATA;
          end
        end
        TX_PRE: begin
          if (!shifter_busy && !load_reg) begin
            load_reg <= 1'b1;
            tx_state_reg <= TX_DATA;
            if (send_break || break_pending_reg) begin
              frame_reg <= 11'h000;
              break_pending_reg <= 1'b0;
            end else begin
              frame_reg <= 11'h7FF;
            end
          end
        end
        TX_DATA: begin
          if (!shifter_busy && !load_reg) begin
            if (send_break || break_pending_reg) begin
              load_reg <= tx_enable;
              frame_reg <= 11'h000;
              break_pending_reg <= 1'b0;
            end else if (idle_pending_reg) begin
              load_reg <= 1'b1;
              frame_reg <= 11'h7FF;
              idle_pending_reg <= 1'b0;
            end else if (tx_enable && tx_data_valid_i) begin
              load_reg <= 1'b1;
              tx_data_taken_o <= 1'b1;
              frame_reg <= long_fmt ? {1'b1, payload, 1'b0}
                                    : {2'b11, payload[7:0], 1'b0};
            end else if (!tx_enable) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Shifter: the line is set high in the same cycle that a frame ends.
  ascc_shifter #(.BITS(BIT_CYC)) u_shift (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(load_reg),
    .frame_i(frame_reg),
    .len_i(long_fmt ? FRAME_LONG : FRAME_SHORT),
    .busy_o(shifter_busy),
    .line_o(shifter_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit flags: module off forces both flags set; a waiting character clears empty; shifter activity clears done.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_empty_flag_reg <= 1'b1;
      tx_done_flag_reg <= 1'b1;
    end else if (!module_enable) begin
      tx_empty_flag_reg <= 1'b1;
      tx_done_flag_reg <= 1'b1;
    end else begin
      if (wr && wb_adr_i == ADDR_CTRL_TWO) begin
        tx_empty_flag_reg <= tx_empty_flag_reg;
      end
      tx_empty_flag_reg <= !tx_data_valid_i || tx_data_taken_o;
      tx_done_flag_reg <= !shifter_busy && !load_reg && tx_state_reg != TX_PRE
                          && !(tx_enable && tx_data_valid_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and requests, all registered.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_line_o <= 1'b1;
      rx_on_o <= 1'b0;
      parity_odd_o <= 1'b0;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_line_o <= shifter_line;
      rx_on_o <= module_enable && ctrl2_reg[C2_RE];
      parity_odd_o <= ctrl1_reg[C1_PTY];
      tx_irq_o <= module_enable
                  && ((ctrl2_reg[C2_TIE] && tx_empty_flag_reg)
                  || (ctrl2_reg[C2_TX_DONE_IRQ_EN] && tx_done_flag_reg));
      rx_irq_o <= !rx_standby
                  && ((ctrl2_reg[C2_RIE] && rx_full_flag_i)
                  || (ctrl2_reg[C2_IDLE_LINE_IRQ_EN] && rx_idle_flag_i));
      err_irq_o <= (ctrl3_reg[C3_OVERRUN_IRQ_EN] && overrun_flag_i)
                   || (ctrl3_reg[C3_NOISE_IRQ_EN] && noise_flag_i)
                   || (ctrl3_reg[C3_FRAMING_IRQ_EN] && framing_flag_i)
                   || (ctrl3_reg[C3_PARITY_ERR_IRQ_EN] && parity_err_flag_i);
    end
  end
endmodule
`default_nettype wire

// ### ascc_top_asserts.sv
// Checker of bus, request and line timing at the serial control block's ports.
`timescale 1ns/10ps
`default_nettype none
module ascc_top_asserts
  import ascc_pkg::*;
#(
  parameter int BIT_CYC = 16 // Clock cycles per bit.
) (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [ascc_pkg::ADDR_W-1:0] wb_adr_i, // Byte address.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic tx_data_valid_i, // Character waits.
  input wire logic tx_data_taken_o, // Character taken.
  input wire logic tx_line_o, // Transmit line.
  input wire logic parity_odd_o, // Parity type.
  input wire logic rx_full_flag_i, // Receiver full.
  input wire logic rx_idle_flag_i, // Receiver idle.
  input wire logic rx_irq_o, // Receiver request.
  input wire logic overrun_flag_i, // Overrun.
  input wire logic noise_flag_i, // Noise.
  input wire logic framing_flag_i, // Framing.
  input wire logic parity_err_flag_i, // Parity error.
  input wire logic err_irq_o // Error request.
);
  logic [15:0] low_cnt; // Cycles the line has stayed low.
  logic w_one; // Write request to control one.
  assign w_one = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == ADDR_CTRL_ONE);
  // Measures each low run so that bit widths can be judged when the line rises.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_cnt <= 16'h0000;
    end else if (!tx_line_o) begin
      low_cnt <= low_cnt + 16'h0001;
    end else begin
      low_cnt <= 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_err_quiet: assert property (
    !(overrun_flag_i || noise_flag_i || framing_flag_i || parity_err_flag_i) |=> !err_irq_o)
    else $error("error request without a flag");
  a_rx_quiet: assert property (!(rx_full_flag_i || rx_idle_flag_i) |=> !rx_irq_o)
    else $error("receive request without a flag");
  a_parity_write: assert property (
    $changed(parity_odd_o) |-> $past(w_one) || $past(w_one, 2) || $past(w_one, 3))
    else $error("parity type moved without a write");
  a_bit_whole: assert property (
    $rose(tx_line_o) |-> low_cnt != 16'h0000 && low_cnt % BIT_CYC == 0)
    else $error("low run not whole bits");
  a_take_valid: assert property (tx_data_taken_o |-> $past(tx_data_valid_i))
    else $error("character taken while none waited");
endmodule
bind ascc_top ascc_top_asserts #(.BIT_CYC(BIT_CYC)) u_asserts (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tx_data_valid_i(tx_data_valid_i), .tx_data_taken_o(tx_data_taken_o),
  .tx_line_o(tx_line_o), .parity_odd_o(parity_odd_o), .rx_full_flag_i(rx_full_flag_i),
  .rx_idle_flag_i(rx_idle_flag_i), .rx_irq_o(rx_irq_o), .overrun_flag_i(overrun_flag_i),
  .noise_flag_i(noise_flag_i), .framing_flag_i(framing_flag_i),
  .parity_err_flag_i(parity_err_flag_i), .err_irq_o(err_irq_o)
);
`default_nettype wire

// ### ascc_far_rx.sv
// Far-end serial receiver that captures each frame seen on the transmit line.
`timescale 1ns/10ps
`default_nettype none
module ascc_far_rx #(
  parameter int BITS = 4 // Clock cycles per bit.
) (
  input wire logic ref_clk_i, // Clock.
  input wire logic line_i, // Serial line from the block.
  input wire logic [3:0] len_i, // Bits per frame.
  output logic [10:0] frame_o, // Last frame, first bit at 0.
  output logic got_o // Toggles after each frame.
);
  // Waits for a start edge, then samples every bit near its middle.
  initial begin
    got_o = 1'b0;
    frame_o = 11'h000;
    forever begin
      @(negedge line_i);
      frame_o = 11'h000;
      repeat (BITS / 2) @(negedge ref_clk_i);
      for (int i = 0; i < int'(len_i); i++) begin
        frame_o[i] = line_i;
        repeat (BITS) @(negedge ref_clk_i);
      end
      got_o = ~got_o;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench of the serial control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ascc_pkg::*;
  localparam int BC = 4; // Short bit period keeps the run brief.
  logic clk, rst, cyc, stb, we, vld, rld, full, idle, wake, g0;
  logic ack, taken, line, rxon, podd, tirq, rirq, eirq, got;
  logic [3:0] adr, ef, flen;
  logic [31:0] wdat, rdat;
  logic [7:0] txd, q;
  logic [8:0] rxc;
  logic [10:0] frm;
  int bad_count, cmp_count;
  ascc_top #(.BIT_CYC(BC)) dut (.ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_i(txd), .tx_data_valid_i(vld),
    .tx_data_taken_o(taken), .rx_load_i(rld), .rx_char_i(rxc), .rx_full_flag_i(full),
    .rx_idle_flag_i(idle), .rx_idle_wake_i(wake), .overrun_flag_i(ef[3]),
    .noise_flag_i(ef[2]), .framing_flag_i(ef[1]), .parity_err_flag_i(ef[0]),
    .tx_line_o(line), .rx_on_o(rxon), .parity_odd_o(podd), .tx_irq_o(tirq),
    .rx_irq_o(rirq), .err_irq_o(eirq));
  ascc_far_rx #(.BITS(BC)) far (.ref_clk_i(clk), .line_i(line), .len_i(flen),
    .frame_o(frm), .got_o(got));
  ////////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    chk("ack wait", n, 1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Reads a register and compares the masked byte.
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("read data", q & m, e);
  endtask
  // Waits for the far end to finish a frame and compares it.
  task automatic frame(input logic [10:0] e);
    int k;
    k = 0;
    while (got === g0 && k < 3000) begin
      k++;
      @(posedge clk);
    end
    g0 = got;
    chk("frame wait", k < 3000, 1'b1);
    chk("frame", frm, e);
  endtask
  // Pulses the receive load strobe with a character.
  task automatic load(input logic [8:0] c);
    rxc <= c;
    rld <= 1'b1;
    @(posedge clk);
    rld <= 1'b0;
  endtask
  // The data register gives up its character once the shifter takes it.
  always @(posedge clk) begin
    if (taken === 1'b1) begin
      vld <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place and plain read back.
  task automatic t_regs;
    rd(ADDR_CTRL_ONE, 8'hFF, 8'h00);
    rd(ADDR_CTRL_TWO, 8'hFF, 8'h00);
    rd(ADDR_CTRL_THREE, 8'h3F, 8'h00);
    rd(ADDR_STATUS_ONE, 8'hFF, 8'hC0);
    rd(4'h6, 8'hFF, 8'h00);
    chk("line", line, 1'b1);
    bus(1'b1, ADDR_CTRL_ONE, 8'h5B);
    rd(ADDR_CTRL_ONE, 8'hFF, 8'h5B);
    chk("parity type", podd, 1'b1);
    bus(1'b1, ADDR_CTRL_THREE, 8'h4F);
    rd(ADDR_CTRL_THREE, 8'h7F, 8'h4F);
  endtask
  // Transmit and error requests with their enables.
  task automatic t_irq;
    bus(1'b1, ADDR_CTRL_ONE, 8'h40);
    bus(1'b1, ADDR_CTRL_TWO, 8'h80);
    repeat (3) @(posedge clk);
    chk("tx request", tirq, 1'b1);
    bus(1'b1, ADDR_CTRL_TWO, 8'h40);
    repeat (3) @(posedge clk);
    chk("tx request", tirq, 1'b1);
    bus(1'b1, ADDR_CTRL_ONE, 8'h00);
    repeat (3) @(posedge clk);
    chk("tx request", tirq, 1'b0);
    bus(1'b1, ADDR_CTRL_ONE, 8'h40);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL_THREE, 8'h40 | (8'h01 << i));
      ef <= 4'h1 << i;
      repeat (3) @(posedge clk);
      chk("error request", eirq, 1'b1);
      ef <= ~(4'h1 << i);
      repeat (3) @(posedge clk);
      chk("error request", eirq, 1'b0);
    end
    ef <= 4'h0;
  endtask
  // Receive requests, standby and its two wake conditions, ninth bit.
  task automatic t_rx;
    bus(1'b1, ADDR_CTRL_TWO, 8'h24);
    full <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rx request", rirq, 1'b1);
    chk("rx on", rxon, 1'b1);
    bus(1'b1, ADDR_CTRL_TWO, 8'h26);
    repeat (3) @(posedge clk);
    chk("rx request", rirq, 1'b0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rx request", rirq, 1'b1);
    rd(ADDR_CTRL_TWO, 8'hFF, 8'h24);
    bus(1'b1, ADDR_CTRL_ONE, 8'h48);
    bus(1'b1, ADDR_CTRL_TWO, 8'h26);
    load(9'h080);
    rd(ADDR_CTRL_TWO, 8'hFF, 8'h24);
    rd(ADDR_CTRL_THREE, 8'h80, 8'h80);
    full <= 1'b0;
    idle <= 1'b1;
    bus(1'b1, ADDR_CTRL_TWO, 8'h14);
    repeat (3) @(posedge clk);
    chk("rx request", rirq, 1'b1);
    idle <= 1'b0;
    bus(1'b1, ADDR_CTRL_ONE, 8'h50);
    load(9'h1A5);
    rd(ADDR_CTRL_THREE, 8'h80, 8'h80);
    bus(1'b1, ADDR_CTRL_ONE, 8'h40);
    load(9'h100);
    rd(ADDR_CTRL_THREE, 8'h80, 8'h00);
  endtask
  // Preamble, parity frame, ninth-bit frame and a break on the line.
  task automatic t_tx;
    int k;
    k = 0;
    bus(1'b1, ADDR_CTRL_ONE, 8'h43);
    flen <= FRAME_SHORT;
    txd <= 8'h35;
    vld <= 1'b1;
    bus(1'b1, ADDR_CTRL_TWO, 8'h08);
    while (line === 1'b1 && k < 500) begin
      k++;
      @(posedge clk);
    end
    chk("preamble", k >= 10 * BC && k < 500, 1'b1);
    frame({1'b1, ~^txd[6:0], txd[6:0], 1'b0});
    bus(1'b1, ADDR_CTRL_ONE, 8'h50);
    bus(1'b1, ADDR_CTRL_THREE, 8'h40);
    flen <= FRAME_LONG;
    txd <= 8'hA6;
    vld <= 1'b1;
    frame({1'b1, 1'b1, 8'hA6, 1'b0});
    chk("data taken", vld, 1'b0);
    bus(1'b1, ADDR_CTRL_TWO, 8'h09);
    bus(1'b1, ADDR_CTRL_TWO, 8'h08);
    frame(11'h000);
    repeat (2 * BC) @(posedge clk);
    chk("line after break", line, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  // Main sequence.
  initial begin
    {rst, cyc, stb, we, vld, rld, full, idle, wake} = 9'h100;
    adr = 4'h0;
    ef = 4'h0;
    flen = FRAME_SHORT;
    wdat = 32'h0000_0000;
    txd = 8'h00;
    rxc = 9'h000;
    g0 = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    t_rx();
    t_tx();
    finish_test();
  end
endmodule
`default_nettype wire
